//--- hdl/smdr_top.sv
// Contract
// RL1 - Status bits 0 to 3 show master, target, observer and trace run state.
// RL2 - Status bit 4 shows a protocol violation while one is detected.
// RL3 - Status bit 5 sets on a data compare mismatch and stays until cleared.
// RL4 - Status bit 6 sets on a functional failure and stays until cleared.
// RL5 - Status bit 7 sets when a block ends unfinished, stays until cleared.
// RL6 - Status bit 12 shows a failed built-in test run, read only.
// RL7 - Interrupt generate drives every selected line, any combination together.
// RL8 - Bits 8 to 11 record asserted lines; clearing a bit releases its line.
// RL9 - Status clear takes a pattern; ones clear bits, zeros leave them.
// RL10 - This status register is independent of the configuration header status.
// RL11 - Send mailbox full flag stays set until the other side reads.
// RL12 - Writing a full send mailbox drops the byte and returns the flag.
// RL13 - Reading the receive mailbox returns byte and valid flag, clearing it.
// RL14 - Receive valid is one only for a message not read before.
// RL15 - Every mailbox message is exactly one byte in both directions.
// RL16 - Mailboxes work identically from the configuration path and external path.
// RL17 - Card display mode, the default, shows the protocol error number.
// RL18 - User display mode shows a software written byte as two digits.
// RL19 - Display writes in card mode are ignored; status reads zero after reset.
module smdr_top
    import smdr_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Configuration space control path.
    input wire logic cfg_req,
    input wire logic [2:0] cfg_op,
    input wire logic [STAT_W-1:0] cfg_wdata,
    output logic cfg_ack,
    output logic [STAT_W-1:0] cfg_rdata,
    // External serial or parallel control path.
    input wire logic ext_req,
    input wire logic [2:0] ext_op,
    input wire logic [STAT_W-1:0] ext_wdata,
    output logic ext_ack,
    output logic [STAT_W-1:0] ext_rdata,
    // Card activity and error sources.
    input wire logic [RUN_N-1:0] run_state,
    input wire logic proto_err,
    input wire logic [DISP_W-1:0] proto_err_code,
    input wire logic cmp_err,
    input wire logic func_err,
    input wire logic blk_abort,
    input wire logic test_fail,
    // Onboard side of the mailboxes.
    input wire logic card_snd_rd,
    input wire logic card_rcv_wr,
    input wire logic [MBX_W-1:0] card_rcv_wdata,
    output logic [MBX_W-1:0] card_snd_data,
    output logic card_snd_full,
    output logic card_rcv_valid,
    // Interrupt lines, open drain, INTA at bit 0.
    output logic [INT_N-1:0] int_out,
    output logic [INT_N-1:0] int_oe,
    // Hex display.
    output logic [DISP_W-1:0] disp_value,
    output logic disp_mode
);
    smdr_mbox_if mb();

    // =================================================================
    // Registers.
    logic [RUN_N-1:0] run_r, run_nxt;
    logic proto_r, proto_nxt;
    logic test_r, test_nxt;
    logic [DISP_W-1:0] code_r, code_nxt;
    logic cmp_r, cmp_nxt;
    logic func_r, func_nxt;
    logic blk_r, blk_nxt;
    logic [INT_N-1:0] int_r, int_nxt;
    logic [INT_N-1:0] int_out_r, int_out_nxt;
    logic cfg_ack_r, cfg_ack_nxt;
    logic ext_ack_r, ext_ack_nxt;
    logic [STAT_W-1:0] cfg_rdata_r, cfg_rdata_nxt;
    logic [STAT_W-1:0] ext_rdata_r, ext_rdata_nxt;
    smdr_disp_t mode_r, mode_nxt;
    logic [DISP_W-1:0] user_r, user_nxt;
    logic [DISP_W-1:0] disp_r, disp_nxt;

    // =================================================================
    // Request selection.
    logic cfg_take, ext_take, take;
    smdr_op_t op;
    logic [STAT_W-1:0] wdata;
    logic [STAT_W-1:0] stat_view;
    logic [STAT_W-1:0] rsp;

    // The configuration path wins a tie; the external path waits.
    assign cfg_take = cfg_req && !cfg_ack_r;
    assign ext_take = ext_req && !ext_ack_r && !cfg_take;
    assign take = cfg_take || ext_take;
    assign op = take ? smdr_op_t'(cfg_take ? cfg_op : ext_op) : SMDR_OP_NONE;
    assign wdata = cfg_take ? cfg_wdata : ext_wdata;

    // Only onboard state is read here, never the configuration header.
    assign stat_view = {{ST_RSVD_W{1'b0}}, test_r, int_r, blk_r, func_r, cmp_r, proto_r, run_r}; // RL10

    // =================================================================
    // Mailbox hookup; both paths drive the same pair of boxes.
    assign mb.snd_wr = (op == SMDR_OP_MBX_SEND); // RL16
    assign mb.snd_wdata = wdata[MBX_W-1:0]; // RL15
    assign mb.rcv_rd = (op == SMDR_OP_MBX_RECV); // RL16
    assign mb.card_snd_rd = card_snd_rd;
    assign mb.card_rcv_wr = card_rcv_wr;
    assign mb.card_rcv_wdata = card_rcv_wdata;

    smdr_mbox u_mbox (
        .sys_clk(sys_clk),
        .reset(reset),
        .mb(mb.mbox)
    );

    // =================================================================
    // Answer to the taken request.
    always_comb begin
        rsp = RSP_RESET;
        case (op)
            SMDR_OP_STAT_READ: begin
                rsp = stat_view;
            end
            SMDR_OP_MBX_SEND: begin
                rsp[RSP_FLAG] = mb.snd_full; // RL12
            end
            SMDR_OP_MBX_RECV: begin
                rsp[MBX_W-1:0] = mb.rcv_data; // RL13
                rsp[RSP_FLAG] = mb.rcv_valid; // RL14
            end
            default: begin
                rsp = RSP_RESET;
            end
        endcase
        cfg_ack_nxt = cfg_take;
        ext_ack_nxt = ext_take;
        cfg_rdata_nxt = cfg_take ? rsp : cfg_rdata_r;
        ext_rdata_nxt = ext_take ? rsp : ext_rdata_r;
    end

    // =================================================================
    // Status register.
    always_comb begin
        run_nxt = run_state; // RL1
        proto_nxt = proto_err; // RL2
        test_nxt = test_fail; // RL6
        code_nxt = proto_err_code;
        cmp_nxt = cmp_r;
        func_nxt = func_r;
        blk_nxt = blk_r;
        int_nxt = int_r;
        int_out_nxt = '0;
        if (op == SMDR_OP_STAT_CLEAR) begin
            cmp_nxt = cmp_r && !wdata[ST_CMP]; // RL9
            func_nxt = func_r && !wdata[ST_FUNC]; // RL9
            blk_nxt = blk_r && !wdata[ST_BLK]; // RL9
            int_nxt = int_r & ~wdata[ST_INT_LO +: INT_N]; // RL8
        end
        if (op == SMDR_OP_INT_GEN) begin
            int_nxt = int_r | wdata[INT_N-1:0]; // RL7
        end
        // Events set after the clear so a coincident event survives.
        if (cmp_err) begin
            cmp_nxt = 1'b1; // RL3
        end
        if (func_err) begin
            func_nxt = 1'b1; // RL4
        end
        if (blk_abort) begin
            blk_nxt = 1'b1; // RL5
        end
    end

    // =================================================================
    // Display.
    always_comb begin
        mode_nxt = mode_r;
        user_nxt = user_r;
        if (op == SMDR_OP_DISP_MODE) begin
            mode_nxt = smdr_disp_t'(wdata[0]);
        end
        // Writes only land once software mode is chosen.
        if (op == SMDR_OP_DISP_WRITE && mode_r == display_software_mode) begin // RL19
            user_nxt = wdata[DISP_W-1:0]; // RL18
        end
        disp_nxt = (mode_r == display_software_mode) ? user_r : code_r; // RL17
    end

    // =================================================================
    // State registers.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            run_r <= '0; // RL19
            proto_r <= 1'b0;
            test_r <= 1'b0;
            code_r <= '0;
            cmp_r <= 1'b0;
            func_r <= 1'b0;
            blk_r <= 1'b0;
            int_r <= '0;
            int_out_r <= '0;
            cfg_ack_r <= 1'b0;
            ext_ack_r <= 1'b0;
            cfg_rdata_r <= RSP_RESET;
            ext_rdata_r <= RSP_RESET;
            mode_r <= display_error_code_mode;
            user_r <= '0;
            disp_r <= '0;
        end else begin
            run_r <= run_nxt;
            proto_r <= proto_nxt;
            test_r <= test_nxt;
            code_r <= code_nxt;
            cmp_r <= cmp_nxt;
            func_r <= func_nxt;
            blk_r <= blk_nxt;
            int_r <= int_nxt;
            int_out_r <= int_out_nxt;
            cfg_ack_r <= cfg_ack_nxt;
            ext_ack_r <= ext_ack_nxt;
            cfg_rdata_r <= cfg_rdata_nxt;
            ext_rdata_r <= ext_rdata_nxt;
            mode_r <= mode_nxt;
            user_r <= user_nxt;
            disp_r <= disp_nxt;
        end
    end

    // =================================================================
    // Outputs.
    assign cfg_ack = cfg_ack_r;
    assign cfg_rdata = cfg_rdata_r;
    assign ext_ack = ext_ack_r;
    assign ext_rdata = ext_rdata_r;
    assign int_out = int_out_r;
    assign int_oe = int_r; // RL8
    assign card_snd_data = mb.snd_data;
    assign card_snd_full = mb.snd_full;
    assign card_rcv_valid = mb.rcv_valid;
    assign disp_value = disp_r;
    assign disp_mode = mode_r;

    // =================================================================
    // Checks.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_run_read;
        cfg_take && op == SMDR_OP_STAT_READ |=> cfg_ack_r && (cfg_rdata_r[RUN_N-1:0] == $past(run_r));
    endproperty
    a_run_read: assert property (p_run_read) else $error("run state misreported"); // RL1

    property p_proto_flag;
        proto_err |=> stat_view[ST_PROTO] && (code_r == $past(proto_err_code));
    endproperty
    a_proto_flag: assert property (p_proto_flag) else $error("protocol flag not shown"); // RL2

    property p_cmp_sticky;
        cmp_err ##1 (op != SMDR_OP_STAT_CLEAR) [*3] |=> stat_view[ST_CMP];
    endproperty
    a_cmp_sticky: assert property (p_cmp_sticky) else $error("compare flag lost"); // RL3

    property p_func_set;
        func_err |=> func_r;
    endproperty
    a_func_set: assert property (p_func_set) else $error("functional flag not set"); // RL4

    property p_blk_set;
        blk_abort |=> stat_view[ST_BLK];
    endproperty
    a_blk_set: assert property (p_blk_set) else $error("block abort flag not set"); // RL5

    property p_test_flag;
        test_fail ##1 test_fail |-> stat_view[ST_TEST];
    endproperty
    a_test_flag: assert property (p_test_flag) else $error("test fail flag not shown"); // RL6

    property p_int_gen;
        op == SMDR_OP_INT_GEN |=> ((int_oe & $past(wdata[INT_N-1:0])) == $past(wdata[INT_N-1:0])) && int_out == '0;
    endproperty
    a_int_gen: assert property (p_int_gen) else $error("selected interrupt not driven"); // RL7

    property p_int_release;
        op == SMDR_OP_STAT_CLEAR |=> (int_oe & $past(wdata[ST_INT_LO +: INT_N])) == '0;
    endproperty
    a_int_release: assert property (p_int_release) else $error("cleared interrupt still driven"); // RL8

    property p_clear_keep;
        op == SMDR_OP_STAT_CLEAR |=> (int_r & ~$past(wdata[ST_INT_LO +: INT_N])) == ($past(int_r) & ~$past(wdata[ST_INT_LO +: INT_N]));
    endproperty
    a_clear_keep: assert property (p_clear_keep) else $error("zero pattern bit changed status"); // RL9

    property p_ack_pulse;
        cfg_ack_r |=> !cfg_ack_r;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held over two cycles"); // RL16

    property p_disp_card;
        mode_r == display_error_code_mode [*2] |-> disp_r == $past(code_r);
    endproperty
    a_disp_card: assert property (p_disp_card) else $error("card mode display wrong"); // RL17

    property p_disp_ignore;
        op == SMDR_OP_DISP_WRITE && mode_r == display_error_code_mode |=> user_r == $past(user_r);
    endproperty
    a_disp_ignore: assert property (p_disp_ignore) else $error("display write taken in card mode"); // RL19
endmodule // smdr_top

//--- hdl/smdr_pkg.sv
// =====================================================================
// Shared constants and types for the status, mailbox and display block.
package smdr_pkg;
    // =================================================================
    // Widths.
    localparam int STAT_W = 32;
    localparam int MBX_W = 8;
    localparam int DISP_W = 8;
    localparam int INT_N = 4;
    localparam int RUN_N = 4;

    // =================================================================
    // Status register bit positions.
    localparam int ST_RUN_LO = 0;
    localparam int ST_PROTO = 4;
    localparam int ST_CMP = 5;
    localparam int ST_FUNC = 6;
    localparam int ST_BLK = 7;
    localparam int ST_INT_LO = 8;
    localparam int ST_TEST = 12;
    localparam int ST_RSVD_W = 19;
    localparam logic [STAT_W-1:0] STAT_RESET = 32'h0000_0000;

    // =================================================================
    // Answer layout: the mailbox flag sits just above the message byte.
    localparam int RSP_FLAG = 8;
    localparam logic [STAT_W-1:0] RSP_RESET = 32'h0000_0000;

    // =================================================================
    // Commands accepted on either control path.
    typedef enum logic [2:0] {
        SMDR_OP_STAT_READ = 3'h0,
        SMDR_OP_STAT_CLEAR = 3'h1,
        SMDR_OP_INT_GEN = 3'h2,
        SMDR_OP_MBX_SEND = 3'h3,
        SMDR_OP_MBX_RECV = 3'h4,
        SMDR_OP_DISP_MODE = 3'h5,
        SMDR_OP_DISP_WRITE = 3'h6,
        SMDR_OP_NONE = 3'h7
    } smdr_op_t;

    // =================================================================
    // Display modes; card mode is the reset default.
    typedef enum logic {
        display_error_code_mode = 1'b0,
        display_software_mode = 1'b1
    } smdr_disp_t;
endpackage : smdr_pkg

//--- hdl/smdr_mbox_if.sv
// =====================================================================
// Signals between the request logic and the mailbox pair.
interface smdr_mbox_if;
    import smdr_pkg::*;
    logic snd_wr;
    logic [MBX_W-1:0] snd_wdata;
    logic rcv_rd;
    logic card_snd_rd;
    logic card_rcv_wr;
    logic [MBX_W-1:0] card_rcv_wdata;
    logic snd_full;
    logic [MBX_W-1:0] snd_data;
    logic rcv_valid;
    logic [MBX_W-1:0] rcv_data;

    modport mbox (
        input snd_wr, snd_wdata, rcv_rd, card_snd_rd, card_rcv_wr, card_rcv_wdata,
        output snd_full, snd_data, rcv_valid, rcv_data
    );
    modport ctrl (
        output snd_wr, snd_wdata, rcv_rd, card_snd_rd, card_rcv_wr, card_rcv_wdata,
        input snd_full, snd_data, rcv_valid, rcv_data
    );
endinterface : smdr_mbox_if

//--- hdl/smdr_mbox.sv
// =====================================================================
// One-byte send and receive mailboxes with full and valid flags.
module smdr_mbox
    import smdr_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Mailbox signals.
    smdr_mbox_if.mbox mb
);
    logic [MBX_W-1:0] snd_data_r, snd_data_nxt;
    logic snd_full_r, snd_full_nxt;
    logic [MBX_W-1:0] rcv_data_r, rcv_data_nxt;
    logic rcv_valid_r, rcv_valid_nxt;

    // =================================================================
    // Next state.
    always_comb begin
        snd_data_nxt = snd_data_r;
        snd_full_nxt = snd_full_r;
        rcv_data_nxt = rcv_data_r;
        rcv_valid_nxt = rcv_valid_r;
        // A write into a full send box is dropped; the old byte stays.
        if (mb.snd_wr && !snd_full_r) begin // RL12
            snd_data_nxt = mb.snd_wdata; // RL15
            snd_full_nxt = 1'b1; // RL11
        end else if (mb.card_snd_rd) begin
            snd_full_nxt = 1'b0; // RL11
        end
        // A new message arriving with a read wins over the clear.
        if (mb.card_rcv_wr) begin
            rcv_data_nxt = mb.card_rcv_wdata; // RL15
            rcv_valid_nxt = 1'b1; // RL14
        end else if (mb.rcv_rd) begin
            rcv_valid_nxt = 1'b0; // RL13
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            snd_data_r <= '0;
            snd_full_r <= 1'b0;
            rcv_data_r <= '0;
            rcv_valid_r <= 1'b0;
        end else begin
            snd_data_r <= snd_data_nxt;
            snd_full_r <= snd_full_nxt;
            rcv_data_r <= rcv_data_nxt;
            rcv_valid_r <= rcv_valid_nxt;
        end
    end

    assign mb.snd_full = snd_full_r;
    assign mb.snd_data = snd_data_r;
    assign mb.rcv_valid = rcv_valid_r;
    assign mb.rcv_data = rcv_data_r;

    // =================================================================
    // Checks.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_send_refuse;
        mb.snd_wr && snd_full_r |=> (snd_full_r || $past(mb.card_snd_rd)) && (snd_data_r == $past(snd_data_r));
    endproperty
    a_send_refuse: assert property (p_send_refuse) else $error("send byte overwritten while full"); // RL12

    property p_send_hold;
        snd_full_r && !mb.card_snd_rd |=> snd_full_r;
    endproperty
    a_send_hold: assert property (p_send_hold) else $error("send full dropped without a read"); // RL11

    property p_recv_clear;
        mb.rcv_rd && !mb.card_rcv_wr |=> !rcv_valid_r;
    endproperty
    a_recv_clear: assert property (p_recv_clear) else $error("receive valid kept after read"); // RL13

    property p_recv_new;
        mb.card_rcv_wr |=> rcv_valid_r && (rcv_data_r == $past(mb.card_rcv_wdata));
    endproperty
    a_recv_new: assert property (p_recv_new) else $error("new receive message not flagged"); // RL14
endmodule // smdr_mbox

//--- sim/smdr_host_model.sv
// =====================================================================
// Host software on one control path, issuing one command at a time.
module smdr_host_model
    import smdr_pkg::*;
(
    // Clock.
    input wire logic sys_clk,
    // Request toward the block.
    output logic req,
    output logic [2:0] op,
    output logic [STAT_W-1:0] wdata,
    // Answer from the block.
    input wire logic ack,
    input wire logic [STAT_W-1:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        req = 1'b0;
        op = SMDR_OP_NONE;
        wdata = 32'h0000_0000;
    end

    // =================================================================
    // One command: hold the request until the answer is sampled, then
    // release. A missing answer leaves the result unknown.
    task automatic xfer(input smdr_op_t cmd, input logic [STAT_W-1:0] wd, output logic [STAT_W-1:0] rd);
        int n;
        n = 0;
        rd = 'x;
        @(posedge sys_clk);
        req <= 1'b1;
        op <= cmd;
        wdata <= wd;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        if (ack === 1'b1) begin
            rd = rdata;
        end
        req <= 1'b0;
        op <= SMDR_OP_NONE;
        wdata <= ~wd;
    endtask
endmodule // smdr_host_model

//--- sim/tb_top.sv
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("ERROR at %0t ns: got %h expected %h", $time, (got), (exp)); \
        end \
    end

module tb_top
    import smdr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk, reset;
    logic cfg_req, cfg_ack, ext_req, ext_ack;
    logic [2:0] cfg_op, ext_op;
    logic [STAT_W-1:0] cfg_wdata, cfg_rdata, ext_wdata, ext_rdata;
    logic [RUN_N-1:0] run_state;
    logic proto_err, cmp_err, func_err, blk_abort, test_fail;
    logic [DISP_W-1:0] proto_err_code, disp_value;
    logic card_snd_rd, card_rcv_wr, card_snd_full, card_rcv_valid, disp_mode;
    logic [MBX_W-1:0] card_rcv_wdata, card_snd_data;
    logic [INT_N-1:0] int_out, int_oe;
    int errors = 0;
    int num_checks = 0;

    smdr_top dut (.sys_clk(sys_clk), .reset(reset),
        .cfg_req(cfg_req), .cfg_op(cfg_op), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .ext_req(ext_req), .ext_op(ext_op), .ext_wdata(ext_wdata), .ext_ack(ext_ack), .ext_rdata(ext_rdata),
        .run_state(run_state), .proto_err(proto_err), .proto_err_code(proto_err_code), .cmp_err(cmp_err),
        .func_err(func_err), .blk_abort(blk_abort), .test_fail(test_fail), .card_snd_rd(card_snd_rd),
        .card_rcv_wr(card_rcv_wr), .card_rcv_wdata(card_rcv_wdata), .card_snd_data(card_snd_data),
        .card_snd_full(card_snd_full), .card_rcv_valid(card_rcv_valid), .int_out(int_out), .int_oe(int_oe),
        .disp_value(disp_value), .disp_mode(disp_mode));
    smdr_host_model cfg_host (.sys_clk(sys_clk), .req(cfg_req), .op(cfg_op), .wdata(cfg_wdata),
        .ack(cfg_ack), .rdata(cfg_rdata));
    smdr_host_model ext_host (.sys_clk(sys_clk), .req(ext_req), .op(ext_op), .wdata(ext_wdata),
        .ack(ext_ack), .rdata(ext_rdata));

    // =================================================================
    // Clock, watchdog and verdict.
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic final_report;
        $display("Checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge sys_clk);
        errors++;
        $display("ERROR at %0t ns: watchdog expired", $time);
        final_report;
    end

    // =================================================================
    // Access helpers.
    task automatic acc(input bit ext, input smdr_op_t cmd, input logic [STAT_W-1:0] wd,
                       output logic [STAT_W-1:0] rd);
        if (ext) begin
            ext_host.xfer(cmd, wd, rd);
        end else begin
            cfg_host.xfer(cmd, wd, rd);
        end
        if ($isunknown(rd)) begin
            errors++;
            $display("ERROR at %0t ns: no answer from the block", $time);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic post_rcv(input logic [MBX_W-1:0] b);
        @(posedge sys_clk);
        card_rcv_wr <= 1'b1;
        card_rcv_wdata <= b;
        @(posedge sys_clk);
        card_rcv_wr <= 1'b0;
        idle(1);
    endtask

    task automatic set_sticky(input logic v);
        @(posedge sys_clk);
        cmp_err <= v;
        func_err <= v;
        blk_abort <= v;
    endtask

    // =================================================================
    // Test sequence.
    initial begin
        logic [STAT_W-1:0] rd;
        int m;
        reset = 1'b1;
        run_state = 4'h0;
        {proto_err, cmp_err, func_err, blk_abort, test_fail} = 5'h00;
        proto_err_code = 8'h00;
        {card_snd_rd, card_rcv_wr} = 2'h0;
        card_rcv_wdata = 8'h00;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        acc(0, SMDR_OP_STAT_READ, 32'h0, rd);
        `CHK(rd, 32'h0000_0000)
        `CHK(disp_mode, 1'b0)
        @(posedge sys_clk);
        run_state <= 4'ha;
        proto_err <= 1'b1;
        proto_err_code <= 8'h2b;
        test_fail <= 1'b1;
        idle(2);
        acc(1, SMDR_OP_STAT_READ, 32'h0, rd);
        `CHK(rd, 32'h0000_101a)
        `CHK(disp_value, 8'h2b)
        acc(0, SMDR_OP_DISP_WRITE, 32'h77, rd);
        idle(2);
        `CHK(disp_value, 8'h2b)
        @(posedge sys_clk);
        run_state <= 4'h0;
        proto_err <= 1'b0;
        test_fail <= 1'b0;
        idle(2);
        acc(0, SMDR_OP_STAT_READ, 32'h0, rd);
        `CHK(rd, 32'h0000_0000)
        set_sticky(1'b1);
        set_sticky(1'b0);
        idle(3);
        acc(0, SMDR_OP_STAT_READ, 32'h0, rd);
        `CHK(rd, 32'h0000_00e0)
        acc(1, SMDR_OP_STAT_CLEAR, 32'h20, rd);
        acc(0, SMDR_OP_STAT_READ, 32'h0, rd);
        `CHK(rd, 32'h0000_00c0)
        acc(0, SMDR_OP_STAT_CLEAR, 32'hffff_ffff, rd);
        acc(1, SMDR_OP_STAT_READ, 32'h0, rd);
        `CHK(rd, 32'h0000_0000)
        for (m = 1; m < 16; m++) begin
            acc(m[0], SMDR_OP_INT_GEN, 32'(m), rd);
            idle(1);
            `CHK(int_oe, 4'(m))
            `CHK(int_out, 4'h0)
            acc(0, SMDR_OP_STAT_READ, 32'h0, rd);
            `CHK(rd, 32'(m) << 8)
            acc(1, SMDR_OP_STAT_CLEAR, 32'h0000_0f00, rd);
            idle(1);
            `CHK(int_oe, 4'h0)
        end
        acc(0, SMDR_OP_INT_GEN, 32'h5, rd);
        acc(1, SMDR_OP_STAT_CLEAR, 32'h0000_0100, rd);
        idle(1);
        `CHK(int_oe, 4'h4)
        acc(0, SMDR_OP_STAT_READ, 32'h0, rd);
        `CHK(rd, 32'h0000_0400)
        acc(0, SMDR_OP_STAT_CLEAR, 32'h0000_0f00, rd);
        acc(0, SMDR_OP_MBX_SEND, 32'ha5, rd);
        `CHK(rd[RSP_FLAG], 1'b0)
        idle(1);
        `CHK(card_snd_full, 1'b1)
        `CHK(card_snd_data, 8'ha5)
        acc(1, SMDR_OP_MBX_SEND, 32'h3c, rd);
        `CHK(rd[RSP_FLAG], 1'b1)
        idle(1);
        `CHK(card_snd_data, 8'ha5)
        @(posedge sys_clk);
        card_snd_rd <= 1'b1;
        @(posedge sys_clk);
        card_snd_rd <= 1'b0;
        idle(1);
        `CHK(card_snd_full, 1'b0)
        acc(1, SMDR_OP_MBX_SEND, 32'h13c, rd);
        `CHK(rd[RSP_FLAG], 1'b0)
        idle(1);
        `CHK(card_snd_data, 8'h3c)
        acc(1, SMDR_OP_MBX_RECV, 32'h0, rd);
        `CHK(rd[RSP_FLAG], 1'b0)
        post_rcv(8'h5a);
        `CHK(card_rcv_valid, 1'b1)
        acc(0, SMDR_OP_MBX_RECV, 32'h0, rd);
        `CHK(rd[8:0], 9'h15a)
        idle(1);
        `CHK(card_rcv_valid, 1'b0)
        acc(0, SMDR_OP_MBX_RECV, 32'h0, rd);
        `CHK(rd[RSP_FLAG], 1'b0)
        post_rcv(8'hc3);
        acc(1, SMDR_OP_MBX_RECV, 32'h0, rd);
        `CHK(rd[8:0], 9'h1c3)
        acc(1, SMDR_OP_DISP_MODE, 32'h1, rd);
        acc(1, SMDR_OP_DISP_WRITE, 32'h9e, rd);
        idle(2);
        `CHK(disp_mode, 1'b1)
        `CHK(disp_value, 8'h9e)
        acc(0, SMDR_OP_NONE, 32'hffff_ffff, rd);
        `CHK(rd, 32'h0000_0000)
        set_sticky(1'b1);
        set_sticky(1'b0);
        idle(2);
        reset <= 1'b1;
        idle(2);
        reset <= 1'b0;
        acc(0, SMDR_OP_STAT_READ, 32'h0, rd);
        `CHK(rd, 32'h0000_0000)
        `CHK(disp_mode, 1'b0)
        `CHK(card_snd_full, 1'b0)
        final_report;
    end
endmodule // tb_top
